// ---- rtl/mcarf_top.sv ----
/*
 memory controller register bank with abort capture, remap toggle,
 flash read front end with two-word prefetch, page latch and lock gate.
 assumes an external address decoder flags undefined addresses, the
 flash array returns data after the programmed wait states, and
 requesters hold a flash read request stable until it is acknowledged.
*/
// What this block does
// [R1] writing one to remap toggle flips page-zero mapping; zero does nothing
// [R2] undefined address flag shows whether last abort hit an undefined location
// [R3] misaligned flag shows whether last abort was caused by misalignment
// [R4] abort size field: 00 byte, 01 half-word, 10 word
// [R5] abort type field: 00 data read, 01 data write, 10 code fetch
// [R6] dma source bit set when dma master issued the last abort
// [R7] cpu source bit set when processor issued the last abort
// [R8] dma sticky bit set once any dma abort has happened
// [R9] cpu sticky bit set once any processor abort has happened
// [R10] abort address register captures full faulting address, zero at reset
// [R11] two word buffers; next word fetched during second read of pair
// [R12] only code fetches use the prefetch buffers, never data reads
// [R13] wait-state field takes zero to three; read timing follows it
// [R14] with zero wait states every flash read completes in one cycle
// [R15] flash accepts byte, half-word and word reads
// [R16] flash reads wrap across the whole internal memory area
// [R17] one wait state: sequential fetches single cycle except the first
// [R18] two or three wait states: fetches alternate programmed count and one
// [R19] write-only page latch reachable across whole region, wrapping by page
// [R20] each lock region bit blocks write and erase there while set
// [R21] second plane has no own security or nvm bits; first governs both
// [R22] sticky bits clear when abort status is read
// [R23] misaligned word or half-word data access aborts; fetches exempt
// [R24] abort goes to all masters; only processor acts on it
// [R25] reserved bits read zero and ignore writes
`timescale 1ns/10ps
`default_nettype none
module mcarf_top
   import mcarf_pkg::*;
#(
   parameter int FL_AW = 18,
   parameter int PAGE_AW = 6,
   parameter int PGN_W = 10,
   parameter int LOCK_N = 16,
   parameter int LOCK_SH = 6,
   parameter int GP_N = 2
)(
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_N,
   // axi4-lite register slave
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   output logic [1:0] S_AXI_BRESP,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   // system bus access check
   input wire logic SYS_VALID,
   input wire logic [31:0] SYS_ADDR,
   input wire logic [1:0] SYS_SIZE,
   input wire logic [1:0] SYS_KIND,
   input wire logic SYS_MASTER_CPU,
   input wire logic SYS_UNDEF,
   output logic SYS_ABORT,
   output logic REMAP_ACTIVE,
   // flash read request
   input wire logic FR_REQ,
   input wire logic [31:0] FR_ADDR,
   input wire logic FR_FETCH,
   output logic FR_ACK,
   output logic [31:0] FR_RDATA,
   // flash array read port
   output logic FL_RD,
   output logic [FL_AW-3:0] FL_ADDR,
   input wire logic [31:0] FL_RDATA,
   // page latch
   input wire logic PB_WE,
   input wire logic [31:0] PB_ADDR,
   input wire logic [31:0] PB_WDATA,
   input wire logic [PAGE_AW-1:0] PB_RIDX,
   output logic [31:0] PB_RDATA,
   // lock and nonvolatile bits
   input wire logic [LOCK_N-1:0] LOCK_NV,
   input wire logic [PGN_W-1:0] OP_PAGE,
   input wire logic OP_REQ,
   output logic OP_ALLOW,
   input wire logic NV_SECURITY,
   input wire logic [GP_N-1:0] NV_GP,
   output logic [1:0] PLANE_SECURE,
   output logic [GP_N-1:0] PLANE_GP
);
   localparam int FLW = FL_AW - 2;
   localparam int RGN_W = $clog2(LOCK_N);

   function automatic mcarf_reg_t reg_dec(input logic [7:0] a);
      if (a == MCARF_OFF_REMAP)
         reg_dec = RG_REMAP;
      else if (a == MCARF_OFF_ASR)
         reg_dec = RG_ASR;
      else if (a == MCARF_OFF_AASR)
         reg_dec = RG_AASR;
      else if (a == MCARF_OFF_FMR)
         reg_dec = RG_FMR;
      else
         reg_dec = RG_NONE;
   endfunction

   function automatic logic misaligned(input logic [1:0] sz, input logic [1:0] kd,
                                       input logic [1:0] a);
      misaligned = (kd != TY_FETCH) &&
                   (((sz == SZ_WORD) && (a != 2'h0)) || ((sz == SZ_HALF) && a[0]));
   endfunction

   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RST_N);

   // ----------------------------------------------------------------
   // axi4-lite write channel
   // ----------------------------------------------------------------
   logic aw_have_q, w_have_q, bvalid_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic [1:0] bresp_q;
   logic aw_now, w_now, wr_fire;
   logic [7:0] wa;
   logic [31:0] wd;
   logic [3:0] ws;
   mcarf_reg_t wdec;

   assign S_AXI_AWREADY = !aw_have_q && !bvalid_q;
   assign S_AXI_WREADY = !w_have_q && !bvalid_q;
   assign aw_now = aw_have_q || S_AXI_AWVALID;
   assign w_now = w_have_q || S_AXI_WVALID;
   assign wr_fire = aw_now && w_now && !bvalid_q;
   assign wa = aw_have_q ? aw_addr_q : S_AXI_AWADDR;
   assign wd = w_have_q ? w_data_q : S_AXI_WDATA;
   assign ws = w_have_q ? w_strb_q : S_AXI_WSTRB;
   assign wdec = reg_dec(wa);
   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP = bresp_q;

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= MCARF_OKAY;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end
      else if (wr_fire)
      begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         bvalid_q <= 1'b1;
         bresp_q <= (wdec == RG_NONE) ? MCARF_SLVERR : MCARF_OKAY;
      end
      else
      begin
         if (S_AXI_AWVALID && S_AXI_AWREADY)
         begin
            aw_have_q <= 1'b1;
            aw_addr_q <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY)
         begin
            w_have_q <= 1'b1;
            w_data_q <= S_AXI_WDATA;
            w_strb_q <= S_AXI_WSTRB;
         end
         if (bvalid_q && S_AXI_BREADY)
            bvalid_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // remap toggle and wait states
   // ----------------------------------------------------------------
   logic remap_q;
   logic [1:0] wst_q;
   logic remap_hit;

   assign remap_hit = wr_fire && (wdec == RG_REMAP) && ws[0] && wd[MCARF_RCR_TOGGLE];
   assign REMAP_ACTIVE = remap_q;

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
         remap_q <= MCARF_REMAP_RST;
      else if (remap_hit)
         remap_q <= !remap_q; // [R1]
   end

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
         wst_q <= MCARF_WST_RST;
      else if (wr_fire && (wdec == RG_FMR) && ws[1])
         wst_q <= wd[MCARF_FMR_WST +: 2]; // [R13]
   end

   AST_REMAP_FLIP: assert property (remap_hit |=> remap_q != $past(remap_q)) // [R1]
      else $error("remap did not toggle");
   AST_REMAP_ZERO: assert property (!remap_hit |=> remap_q == $past(remap_q)) // [R1]
      else $error("remap changed without a toggle write");

   // ----------------------------------------------------------------
   // abort detection and capture
   // ----------------------------------------------------------------
   logic undef_q, mis_q, dma_src_q, cpu_src_q, dma_stk_q, cpu_stk_q;
   logic [1:0] sz_q, typ_q;
   logic [31:0] aasr_q, asr_val;
   logic mis_now, asr_rd;

   assign mis_now = misaligned(SYS_SIZE, SYS_KIND, SYS_ADDR[1:0]);
   assign SYS_ABORT = SYS_VALID && (SYS_UNDEF || mis_now); // [R23] [R24]

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         undef_q <= 1'b0;
         mis_q <= 1'b0;
         sz_q <= 2'h0;
         typ_q <= 2'h0;
         dma_src_q <= 1'b0;
         cpu_src_q <= 1'b0;
         aasr_q <= MCARF_AASR_RST;
      end
      else if (SYS_ABORT)
      begin
         undef_q <= SYS_UNDEF; // [R2]
         mis_q <= mis_now; // [R3]
         sz_q <= SYS_SIZE; // [R4]
         typ_q <= SYS_KIND; // [R5]
         dma_src_q <= !SYS_MASTER_CPU; // [R6]
         cpu_src_q <= SYS_MASTER_CPU; // [R7]
         aasr_q <= SYS_ADDR; // [R10]
      end
   end

   // set wins over the clear on read
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         dma_stk_q <= 1'b0;
         cpu_stk_q <= 1'b0;
      end
      else
      begin
         if (SYS_ABORT && !SYS_MASTER_CPU)
            dma_stk_q <= 1'b1; // [R8]
         else if (asr_rd)
            dma_stk_q <= 1'b0; // [R22]
         if (SYS_ABORT && SYS_MASTER_CPU)
            cpu_stk_q <= 1'b1; // [R9]
         else if (asr_rd)
            cpu_stk_q <= 1'b0; // [R22]
      end
   end

   always_comb
   begin
      asr_val = 32'h0000_0000; // [R25]
      asr_val[MCARF_ASR_UNDEF] = undef_q;
      asr_val[MCARF_ASR_MIS] = mis_q;
      asr_val[MCARF_ASR_SZ +: 2] = sz_q;
      asr_val[MCARF_ASR_TYP +: 2] = typ_q;
      asr_val[MCARF_ASR_DMA_SRC] = dma_src_q;
      asr_val[MCARF_ASR_CPU_SRC] = cpu_src_q;
      asr_val[MCARF_ASR_DMA_STK] = dma_stk_q;
      asr_val[MCARF_ASR_CPU_STK] = cpu_stk_q;
   end

   AST_UNDEF: assert property (SYS_ABORT |=> undef_q == $past(SYS_UNDEF)) // [R2]
      else $error("undefined flag not captured");
   AST_MIS: assert property (SYS_ABORT && !SYS_UNDEF |=> mis_q) // [R3]
      else $error("misaligned flag not captured");
   AST_SIZE_TYPE: assert property (SYS_ABORT |=> (sz_q == $past(SYS_SIZE)) // [R4]
      && (typ_q == $past(SYS_KIND))) // [R5]
      else $error("abort size or type wrong");
   AST_SRC: assert property (SYS_ABORT |=> (cpu_src_q == $past(SYS_MASTER_CPU)) // [R7]
      && (dma_src_q != cpu_src_q)) // [R6]
      else $error("abort source wrong");
   AST_STICKY: assert property (SYS_ABORT && SYS_MASTER_CPU |=> cpu_stk_q) // [R9]
      else $error("cpu sticky not set");
   AST_STK_CLR: assert property (asr_rd && !SYS_ABORT |=> !dma_stk_q && !cpu_stk_q) // [R22]
      else $error("sticky bits not cleared on read");
   AST_ADDR: assert property (SYS_ABORT |=> aasr_q == $past(SYS_ADDR)) // [R10]
      else $error("abort address not captured");
   AST_ALIGN: assert property (SYS_VALID && mis_now |-> SYS_ABORT) // [R23]
      else $error("misaligned access not aborted");

   // ----------------------------------------------------------------
   // axi4-lite read channel
   // ----------------------------------------------------------------
   logic rvalid_q, ar_fire;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   mcarf_reg_t rdec;

   assign S_AXI_ARREADY = !rvalid_q;
   assign ar_fire = S_AXI_ARVALID && !rvalid_q;
   assign rdec = reg_dec(S_AXI_ARADDR);
   assign asr_rd = ar_fire && (rdec == RG_ASR);
   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RDATA = rdata_q;
   assign S_AXI_RRESP = rresp_q;

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= MCARF_OKAY;
      end
      else if (ar_fire)
      begin
         rvalid_q <= 1'b1;
         rresp_q <= (rdec == RG_NONE) ? MCARF_SLVERR : MCARF_OKAY;
         case (rdec)
            RG_ASR: rdata_q <= asr_val;
            RG_AASR: rdata_q <= aasr_q;
            RG_FMR: rdata_q <= 32'(wst_q) << MCARF_FMR_WST;
            default: rdata_q <= 32'h0000_0000; // [R25]
         endcase
      end
      else if (S_AXI_RREADY)
         rvalid_q <= 1'b0;
   end

   // ----------------------------------------------------------------
   // flash read path with two prefetch words
   // ----------------------------------------------------------------
   mcarf_fstate_t st_q;
   logic [31:0] buf_d_q [2];
   logic [FLW-1:0] buf_t_q [2];
   logic [1:0] buf_v_q;
   logic last_q, pf_busy_q;
   logic [1:0] acc_cnt_q, pf_cnt_q;
   logic [FLW-1:0] pf_addr_q;
   logic [FLW-1:0] rw, nw;
   logic [1:0] hit_v;
   logic hit, fwd, pf_done, miss_go, acc_done, pf_start, nxt_buf;

   assign rw = FR_ADDR[FL_AW-1:2]; // [R16] [R15]
   assign nw = rw + FLW'(1);
   assign hit_v[0] = buf_v_q[0] && (buf_t_q[0] == rw);
   assign hit_v[1] = buf_v_q[1] && (buf_t_q[1] == rw);
   assign nxt_buf = (buf_v_q[0] && (buf_t_q[0] == nw)) || (buf_v_q[1] && (buf_t_q[1] == nw));
   assign hit = (st_q == FS_IDLE) && FR_REQ && FR_FETCH && (hit_v != 2'h0); // [R12]
   assign pf_done = pf_busy_q && (pf_cnt_q == wst_q);
   assign fwd = (st_q == FS_IDLE) && FR_REQ && FR_FETCH && !hit && pf_done &&
                (pf_addr_q == rw); // [R12]
   assign miss_go = (st_q == FS_IDLE) && FR_REQ && !hit && !fwd && !pf_busy_q;
   assign acc_done = (st_q == FS_ACC) && (acc_cnt_q == wst_q); // [R13]
   // look ahead while the second half-word of a word is served
   assign pf_start = hit && FR_ADDR[1] && (wst_q != 2'h0) && !nxt_buf && !pf_busy_q; // [R11]
   assign FR_ACK = hit || fwd || (miss_go && (wst_q == 2'h0)) || acc_done; // [R14]
   assign FR_RDATA = hit ? (hit_v[0] ? buf_d_q[0] : buf_d_q[1]) : FL_RDATA;
   assign FL_RD = (st_q == FS_ACC) || pf_busy_q || pf_start || miss_go;
   assign FL_ADDR = (st_q == FS_ACC) ? rw : pf_busy_q ? pf_addr_q : pf_start ? nw : rw;

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         st_q <= FS_IDLE;
         acc_cnt_q <= 2'h0;
      end
      else
         case (st_q)
            FS_IDLE:
               if (miss_go && (wst_q != 2'h0))
               begin
                  st_q <= FS_ACC;
                  acc_cnt_q <= 2'h1;
               end
            FS_ACC:
               if (acc_done)
                  st_q <= FS_IDLE;
               else
                  acc_cnt_q <= acc_cnt_q + 2'h1;
            default: st_q <= FS_IDLE;
         endcase
   end

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         pf_busy_q <= 1'b0;
         pf_cnt_q <= 2'h0;
         pf_addr_q <= '0;
      end
      else if (pf_start)
      begin
         pf_busy_q <= 1'b1;
         pf_cnt_q <= 2'h1;
         pf_addr_q <= nw; // [R11]
      end
      else if (pf_done)
         pf_busy_q <= 1'b0;
      else if (pf_busy_q)
         pf_cnt_q <= pf_cnt_q + 2'h1;
   end

   // code misses and prefetches fill the word not used last
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         buf_v_q <= 2'h0;
         last_q <= 1'b0;
         buf_d_q[0] <= 32'h0000_0000;
         buf_d_q[1] <= 32'h0000_0000;
         buf_t_q[0] <= '0;
         buf_t_q[1] <= '0;
      end
      else if (pf_done)
      begin
         buf_d_q[!last_q] <= FL_RDATA;
         buf_t_q[!last_q] <= pf_addr_q;
         buf_v_q[!last_q] <= 1'b1;
         last_q <= !last_q;
      end
      else if (FR_ACK && FR_FETCH && !hit)
      begin
         buf_d_q[!last_q] <= FL_RDATA;
         buf_t_q[!last_q] <= rw;
         buf_v_q[!last_q] <= 1'b1;
         last_q <= !last_q;
      end
      else if (hit)
         last_q <= hit_v[1];
   end

   sequence s_wait3;
      !pf_done ##1 !pf_done ##1 pf_done;
   endsequence
   AST_WST0: assert property (FR_REQ && (st_q == FS_IDLE) && !pf_busy_q &&
      (wst_q == 2'h0) |-> FR_ACK) // [R14]
      else $error("zero wait read not single cycle");
   AST_DATA_NOBUF: assert property (FR_REQ && !FR_FETCH |-> !hit && !fwd) // [R12]
      else $error("data read served from prefetch");
   AST_WST1: assert property (pf_start && (wst_q == 2'h1) |=> pf_done) // [R17]
      else $error("one wait prefetch late");
   AST_WST3: assert property (pf_start && (wst_q == 2'h3) |=> s_wait3) // [R18]
      else $error("three wait prefetch timing wrong");

   // ----------------------------------------------------------------
   // page latch, lock gate, nonvolatile bits
   // ----------------------------------------------------------------
   logic [31:0] pb_mem [2**PAGE_AW];
   logic [PAGE_AW-1:0] pb_idx;
   logic [RGN_W-1:0] rgn;

   assign pb_idx = PB_ADDR[PAGE_AW+1:2];
   assign rgn = RGN_W'(OP_PAGE >> LOCK_SH);
   assign OP_ALLOW = OP_REQ && !LOCK_NV[rgn]; // [R20]

   always_ff @(posedge CORE_CLK)
   begin
      if (PB_WE)
         pb_mem[pb_idx] <= PB_WDATA; // [R19]
   end

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         PB_RDATA <= 32'h0000_0000;
         PLANE_SECURE <= 2'h0;
         PLANE_GP <= '0;
      end
      else
      begin
         PB_RDATA <= pb_mem[PB_RIDX];
         PLANE_SECURE <= {2{NV_SECURITY}}; // [R21]
         PLANE_GP <= NV_GP; // [R21]
      end
   end

   AST_LOCK: assert property (OP_REQ && LOCK_NV[rgn] |-> !OP_ALLOW) // [R20]
      else $error("locked region not blocked");
   AST_PB_WR: assert property (PB_WE ##1 !PB_WE |-> pb_mem[$past(pb_idx)] ==
      $past(PB_WDATA)) // [R19]
      else $error("page latch word not stored");
endmodule
`default_nettype wire

// ---- shared/mcarf_pkg.sv ----
/*
 memory controller abort capture, remap and flash read front end:
 register map, field positions, reset values and encodings.
 assumes a 32-bit AXI4-Lite register bus decoded on its low 8 bits.
*/
`default_nettype none
package mcarf_pkg;
   // -------------------------------------------------------------
   // register offsets
   // -------------------------------------------------------------
   localparam logic [7:0] MCARF_OFF_REMAP = 8'h00;
   localparam logic [7:0] MCARF_OFF_ASR = 8'h04;
   localparam logic [7:0] MCARF_OFF_AASR = 8'h08;
   localparam logic [7:0] MCARF_OFF_FMR = 8'h60;
   // -------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------
   localparam int MCARF_RCR_TOGGLE = 0;
   localparam int MCARF_ASR_UNDEF = 0;
   localparam int MCARF_ASR_MIS = 1;
   localparam int MCARF_ASR_SZ = 8;
   localparam int MCARF_ASR_TYP = 10;
   localparam int MCARF_ASR_DMA_SRC = 16;
   localparam int MCARF_ASR_CPU_SRC = 17;
   localparam int MCARF_ASR_DMA_STK = 24;
   localparam int MCARF_ASR_CPU_STK = 25;
   localparam int MCARF_FMR_WST = 8;
   // -------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------
   localparam logic [31:0] MCARF_AASR_RST = 32'h0000_0000;
   localparam logic [1:0] MCARF_WST_RST = 2'h0;
   localparam logic MCARF_REMAP_RST = 1'b0;
   // -------------------------------------------------------------
   // encodings
   // -------------------------------------------------------------
   typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_HALF = 2'h1, SZ_WORD = 2'h2} mcarf_size_t;
   typedef enum logic [1:0] {TY_DREAD = 2'h0, TY_DWRITE = 2'h1, TY_FETCH = 2'h2} mcarf_kind_t;
   typedef enum logic [2:0] {RG_REMAP, RG_ASR, RG_AASR, RG_FMR, RG_NONE} mcarf_reg_t;
   typedef enum logic {FS_IDLE = 1'b0, FS_ACC = 1'b1} mcarf_fstate_t;
   localparam logic [1:0] MCARF_OKAY = 2'h0;
   localparam logic [1:0] MCARF_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ---- tb/mcarf_flash_model.sv ----
/*
 flash array read model: one fixed word per index, settled only after the
 index has been held for the programmed wait states plus one cycle.
 assumes the bench hands over the same wait-state value as the design.
*/
`timescale 1ns/10ps
`default_nettype none
module mcarf_flash_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // array read port
   input wire logic rd,
   input wire logic [15:0] addr,
   input wire logic [1:0] wst,
   output logic [31:0] rdata
);
   logic [15:0] addr_q;
   logic rd_q;
   logic [2:0] held_q;
   logic [2:0] held_d;
   logic [31:0] word;
   assign word = {addr ^ 16'ha5c3, addr};
   assign held_d = (rd && rd_q && addr == addr_q) ? held_q + {2'h0, held_q != 3'h7} : 3'h0;
   // early or idle reads see inverted data, never the settled word
   assign rdata = (rd && held_d >= {1'b0, wst}) ? word : ~word;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         addr_q <= 16'h0;
         rd_q <= 1'b0;
         held_q <= 3'h0;
      end
      else
      begin
         addr_q <= addr;
         rd_q <= rd;
         held_q <= held_d;
      end
   end
endmodule
`default_nettype wire

// ---- tb/tb_memctl_abort_remap_flash_read.sv ----
/*
 self-checking bench: register bus, remap, abort capture, flash timing.
 assumes the flash model above stands on the array read port.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_memctl_abort_remap_flash_read
   import mcarf_pkg::*;
;
   logic clk, rst_n, aw_v, w_v, b_r, ar_v, r_r, sys_v, cpu, undef, fr_req, fr_fetch;
   logic pb_we, op_req, nv_sec, aw_rdy, w_rdy, b_v, ar_rdy, r_v, abort, remap, fr_ack;
   logic fl_rd, op_allow;
   logic [7:0] aw_a, ar_a;
   logic [31:0] w_d, sys_a, fr_a, pb_a, pb_d, rdata, fr_d, fl_d, pb_rd;
   logic [3:0] w_s;
   logic [1:0] sys_sz, sys_k, wst, r, bresp, rresp, psec, pgp, nv_gp;
   logic [5:0] pb_ri;
   logic [15:0] lock_nv, fl_a;
   logic [9:0] op_pg;
   int failures, n_compared;
   mcarf_top DUT (.CORE_CLK(clk), .RST_N(rst_n), .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(aw_rdy),
      .S_AXI_AWADDR(aw_a), .S_AXI_WVALID(w_v), .S_AXI_WREADY(w_rdy), .S_AXI_WDATA(w_d),
      .S_AXI_WSTRB(w_s), .S_AXI_BVALID(b_v), .S_AXI_BREADY(b_r), .S_AXI_BRESP(bresp),
      .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(ar_rdy), .S_AXI_ARADDR(ar_a), .S_AXI_RVALID(r_v),
      .S_AXI_RREADY(r_r), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .SYS_VALID(sys_v),
      .SYS_ADDR(sys_a), .SYS_SIZE(sys_sz), .SYS_KIND(sys_k), .SYS_MASTER_CPU(cpu),
      .SYS_UNDEF(undef), .SYS_ABORT(abort), .REMAP_ACTIVE(remap), .FR_REQ(fr_req),
      .FR_ADDR(fr_a), .FR_FETCH(fr_fetch), .FR_ACK(fr_ack), .FR_RDATA(fr_d), .FL_RD(fl_rd),
      .FL_ADDR(fl_a), .FL_RDATA(fl_d), .PB_WE(pb_we), .PB_ADDR(pb_a), .PB_WDATA(pb_d),
      .PB_RIDX(pb_ri), .PB_RDATA(pb_rd), .LOCK_NV(lock_nv), .OP_PAGE(op_pg), .OP_REQ(op_req),
      .OP_ALLOW(op_allow), .NV_SECURITY(nv_sec), .NV_GP(nv_gp), .PLANE_SECURE(psec),
      .PLANE_GP(pgp));
   mcarf_flash_model FLASH (.clk(clk), .rst_n(rst_n), .rd(fl_rd), .addr(fl_a), .wst(wst),
      .rdata(fl_d));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task final_report;
      if (failures == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
         failures++;
      end
   endtask
   task fail_out;
      failures++;
      final_report;
   endtask
   task axi_wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      logic ah, wh, bh;
      @(posedge clk);
      aw_v <= 1'b1;
      w_v <= 1'b1;
      aw_a <= a;
      w_d <= d;
      b_r <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(negedge clk);
         ah = aw_v && aw_rdy;
         wh = w_v && w_rdy;
         bh = b_v;
         r = bresp;
         @(posedge clk);
         if (ah) aw_v <= 1'b0;
         if (wh) w_v <= 1'b0;
         if (bh) break;
      end
      b_r <= 1'b0;
      if (n == 40) fail_out;
   endtask
   task rd_chk(input logic [7:0] a, input logic [31:0] e);
      int n;
      logic ah, rh;
      logic [31:0] d;
      @(posedge clk);
      ar_v <= 1'b1;
      ar_a <= a;
      r_r <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(negedge clk);
         ah = ar_v && ar_rdy;
         rh = r_v;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ah) ar_v <= 1'b0;
         if (rh) break;
      end
      r_r <= 1'b0;
      if (n == 40) fail_out;
      chk(d, e);
   endtask
   task sys(input logic [31:0] a, input logic [1:0] sz, k, input logic c, u, ex);
      @(posedge clk);
      sys_v <= 1'b1;
      sys_a <= a;
      sys_sz <= sz;
      sys_k <= k;
      cpu <= c;
      undef <= u;
      @(negedge clk);
      chk(32'(abort), 32'(ex));
      @(posedge clk);
      sys_v <= 1'b0;
   endtask
   task fr(input logic [31:0] a, input logic ft, last, input int ex);
      int n;
      logic ak;
      logic [31:0] d;
      fr_req <= 1'b1;
      fr_a <= a;
      fr_fetch <= ft;
      for (n = 1; n < 40; n++)
      begin
         @(negedge clk);
         ak = fr_ack;
         d = fr_d;
         @(posedge clk);
         if (ak === 1'b1) break;
      end
      if (last) fr_req <= 1'b0;
      if (n == 40) fail_out;
      chk(n, ex);
      chk(d, {a[17:2] ^ 16'ha5c3, a[17:2]});
   endtask
   task automatic t_regs;
      logic [31:0] wd [4] = '{32'h1, 32'h0, 32'hffff_fffe, 32'h1};
      logic [31:0] ex [4] = '{32'h1, 32'h1, 32'h1, 32'h0};
      rd_chk(MCARF_OFF_ASR, 32'h0);
      rd_chk(MCARF_OFF_AASR, MCARF_AASR_RST);
      rd_chk(8'h40, 32'h0);
      chk(32'(r), 32'(MCARF_SLVERR));
      for (int i = 0; i < 4; i++)
      begin
         axi_wr(MCARF_OFF_REMAP, wd[i]);
         @(negedge clk);
         chk(32'(remap), ex[i]);
      end
      axi_wr(8'h40, 32'h1);
      chk(32'(r), 32'(MCARF_SLVERR));
      chk(32'(remap), 32'h0);
      rd_chk(MCARF_OFF_REMAP, 32'h0);
   endtask
   task t_abort;
      sys(32'hf000_0001, SZ_WORD, TY_FETCH, 1'b1, 1'b1, 1'b1);
      rd_chk(MCARF_OFF_ASR, 32'h0202_0a01);
      rd_chk(MCARF_OFF_AASR, 32'hf000_0001);
      rd_chk(MCARF_OFF_ASR, 32'h0002_0a01);
      sys(32'h0020_0003, SZ_HALF, TY_DWRITE, 1'b0, 1'b0, 1'b1);
      sys(32'h0020_0007, SZ_BYTE, TY_DREAD, 1'b1, 1'b0, 1'b0);
      sys(32'h0000_0002, SZ_WORD, TY_FETCH, 1'b1, 1'b0, 1'b0);
      rd_chk(MCARF_OFF_ASR, 32'h0101_0502);
      rd_chk(MCARF_OFF_AASR, 32'h0020_0003);
      axi_wr(MCARF_OFF_ASR, 32'hffff_ffff);
      chk(32'(r), 32'(MCARF_OKAY));
      rd_chk(MCARF_OFF_ASR, 32'h0001_0502);
      sys(32'h3000_0000, SZ_WORD, TY_DREAD, 1'b0, 1'b1, 1'b1);
      rd_chk(MCARF_OFF_ASR, 32'h0101_0201);
   endtask
   task t_flash;
      logic [31:0] b;
      for (int f = 0; f < 4; f++)
      begin
         wst <= 2'(f);
         b = 32'h0014_0000 + 32'(f) * 32'h100;
         axi_wr(MCARF_OFF_FMR, 32'(f) << 8);
         rd_chk(MCARF_OFF_FMR, 32'(f) << MCARF_FMR_WST);
         fr(b, 1'b1, 1'b0, f + 1);
         fr(b + 32'h2, 1'b1, 1'b0, 1);
         fr(b + 32'h4, 1'b1, 1'b0, (f == 0) ? 1 : f);
         fr(b + 32'h6, 1'b1, 1'b1, 1);
         repeat (8) @(posedge clk);
         fr(b + 32'h4, 1'b0, 1'b1, f + 1);
      end
   endtask
   task t_misc;
      @(posedge clk);
      pb_we <= 1'b1;
      pb_a <= 32'h000f_ff10;
      pb_d <= 32'h1234_5678;
      @(posedge clk);
      {pb_we, pb_ri, lock_nv, op_pg, op_req, nv_sec, nv_gp} <= {1'b0, 6'h04, 16'h0004, 10'd128, 4'hd};
      @(posedge clk);
      @(negedge clk);
      chk(pb_rd, 32'h1234_5678);
      chk({28'h0, psec, pgp}, 32'hc + 32'(nv_gp));
      chk(32'(op_allow), 32'h0);
      @(posedge clk);
      op_pg <= 10'd192;
      @(negedge clk);
      chk(32'(op_allow), 32'h1);
   endtask
   initial
   begin
      {aw_v, w_v, b_r, ar_v, r_r, sys_v, cpu, undef, fr_req, fr_fetch, pb_we, op_req} = '0;
      {nv_sec, aw_a, ar_a, w_d, sys_a, fr_a, pb_a, pb_d, sys_sz, sys_k, wst, nv_gp} = '0;
      {pb_ri, lock_nv, op_pg, failures, n_compared} = '0;
      w_s = 4'hf;
      rst_n = 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      t_regs;
      t_abort;
      t_flash;
      t_misc;
      final_report;
   end
endmodule
`default_nettype wire
